// ### pkg/cprsf_pkg.sv
package cprsf_pkg;

	// ------------------------------------------------------------
	// register selectors, shared by the software port and datapath
	// ------------------------------------------------------------
	localparam logic [4:0] SEL_DATA_REG_0      = 5'h00;
	localparam logic [4:0] SEL_DATA_REG_1      = 5'h01;
	localparam logic [4:0] SEL_DATA_REG_2      = 5'h02;
	localparam logic [4:0] SEL_DATA_REG_3      = 5'h03;
	localparam logic [4:0] SEL_ADDR_REG_0      = 5'h04;
	localparam logic [4:0] SEL_ADDR_REG_1      = 5'h05;
	localparam logic [4:0] SEL_FRAME_BASE      = 5'h06;
	localparam logic [4:0] SEL_STATIC_BASE     = 5'h07;
	localparam logic [4:0] SEL_USER_STACK_PTR  = 5'h08;
	localparam logic [4:0] SEL_IRQ_STACK_PTR   = 5'h09;
	localparam logic [4:0] SEL_ACTIVE_SP       = 5'h0A;
	localparam logic [4:0] SEL_VECTOR_TBL_BASE = 5'h0B;
	localparam logic [4:0] SEL_INSTR_POINTER   = 5'h0C;
	localparam logic [4:0] SEL_CPU_FLAGS       = 5'h0D;
	localparam logic [4:0] SEL_DATA_REG_0_HIGH = 5'h0E;
	localparam logic [4:0] SEL_DATA_REG_0_LOW  = 5'h0F;
	localparam logic [4:0] SEL_DATA_REG_1_HIGH = 5'h10;
	localparam logic [4:0] SEL_DATA_REG_1_LOW  = 5'h11;
	localparam logic [4:0] SEL_WIDE_PAIR_LO    = 5'h12;
	localparam logic [4:0] SEL_WIDE_PAIR_HI    = 5'h13;
	localparam logic [4:0] SEL_WIDE_ADDR_PAIR  = 5'h14;

	// ------------------------------------------------------------
	// banked register slots
	// ------------------------------------------------------------
	localparam int BK_D0    = 0;
	localparam int BK_D1    = 1;
	localparam int BK_D2    = 2;
	localparam int BK_D3    = 3;
	localparam int BK_A0    = 4;
	localparam int BK_A1    = 5;
	localparam int BK_FB    = 6;
	localparam int BK_SLOTS = 7;
	localparam int BANKS    = 2;

	// ------------------------------------------------------------
	// flag bit positions
	// ------------------------------------------------------------
	localparam int FLG_C    = 0;
	localparam int FLG_D    = 1;
	localparam int FLG_Z    = 2;
	localparam int FLG_S    = 3;
	localparam int FLG_B    = 4;
	localparam int FLG_O    = 5;
	localparam int FLG_I    = 6;
	localparam int FLG_U    = 7;
	localparam int FLG_IPL_LO = 8;
	localparam int FLG_IPL_HI = 10;

	// ------------------------------------------------------------
	// reset values and constants
	// ------------------------------------------------------------
	localparam logic [15:0] RST_WORD   = 16'h0000;
	localparam logic [19:0] RST_ADDR20 = 20'h00000;
	localparam logic [10:0] RST_FLAGS  = 11'h000;
	localparam logic [5:0]  SWI_SYS_MAX = 6'h1F;
	localparam logic [1:0]  SZ_BYTE = 2'h0;
	localparam logic [1:0]  SZ_WORD = 2'h1;
	localparam logic [1:0]  SZ_LONG = 2'h2;

	typedef logic [15:0] cprsf_word_t;

	typedef struct packed {
		logic [4:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} cprsf_bus_t;

	typedef struct packed {
		logic        upd;
		logic        carry;
		logic        ovf;
		logic [1:0]  size;
		logic [31:0] result;
	} cprsf_alu_t;

	typedef struct packed {
		logic       req;
		logic [2:0] prio;
		logic       ack;
		logic       swi;
		logic [5:0] swi_num;
	} cprsf_irq_t;

	typedef struct packed {
		cprsf_word_t [BANKS-1:0][BK_SLOTS-1:0] bank;
		logic [19:0] vector_table_base;
		logic [19:0] pc;
		cprsf_word_t user_stack_ptr;
		cprsf_word_t irq_stack_ptr;
		cprsf_word_t sb;
		logic [10:0] cpu_flags;
		logic [31:0] bus_rdata;
		logic [31:0] dp_rdata;
		cprsf_word_t sp_view;
		logic        irq_take;
	} cprsf_state_t;

endpackage : cprsf_pkg

// ### hw/cprsf_core.sv
`timescale 1ns/100ps
module cprsf_core (
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  srst_in,
	// software register port
	input  wire cprsf_pkg::cprsf_bus_t bus_in,
	output logic [31:0]                bus_rdata_out,
	// datapath register access
	input  wire logic [4:0]            dp_rd_sel_in,
	input  wire logic                  dp_wr_in,
	input  wire logic [4:0]            dp_wr_sel_in,
	input  wire logic [31:0]           dp_wdata_in,
	output logic [31:0]                dp_rdata_out,
	// alu status
	input  wire cprsf_pkg::cprsf_alu_t alu_in,
	// interrupt control
	input  wire cprsf_pkg::cprsf_irq_t irq_in,
	output logic                       irq_take_out,
	// state views
	output logic [10:0]                cpu_flags_out,
	output logic [19:0]                instr_pointer_out,
	output logic [19:0]                vector_table_base_out,
	output logic [15:0]                active_sp_out
);

	// ------------------------------------------------------------
	// register read decode
	// ------------------------------------------------------------
	function automatic logic [31:0] rd_reg(
		input cprsf_pkg::cprsf_state_t s,
		input logic [4:0]              sel
	);
		logic        b;
		logic [31:0] v;
		b = s.cpu_flags[cprsf_pkg::FLG_B];
		v = 32'h0;
		case (sel)
			cprsf_pkg::SEL_DATA_REG_0:
				v = {16'h0, s.bank[b][cprsf_pkg::BK_D0]};
			cprsf_pkg::SEL_DATA_REG_1:
				v = {16'h0, s.bank[b][cprsf_pkg::BK_D1]};
			cprsf_pkg::SEL_DATA_REG_2:
				v = {16'h0, s.bank[b][cprsf_pkg::BK_D2]};
			cprsf_pkg::SEL_DATA_REG_3:
				v = {16'h0, s.bank[b][cprsf_pkg::BK_D3]};
			cprsf_pkg::SEL_ADDR_REG_0:
				v = {16'h0, s.bank[b][cprsf_pkg::BK_A0]};
			cprsf_pkg::SEL_ADDR_REG_1:
				v = {16'h0, s.bank[b][cprsf_pkg::BK_A1]};
			cprsf_pkg::SEL_FRAME_BASE:
				v = {16'h0, s.bank[b][cprsf_pkg::BK_FB]};
			cprsf_pkg::SEL_STATIC_BASE:
				v = {16'h0, s.sb};
			cprsf_pkg::SEL_USER_STACK_PTR:
				v = {16'h0, s.user_stack_ptr};
			cprsf_pkg::SEL_IRQ_STACK_PTR:
				v = {16'h0, s.irq_stack_ptr};
			cprsf_pkg::SEL_ACTIVE_SP:
				v = {16'h0, s.cpu_flags[cprsf_pkg::FLG_U] ? s.user_stack_ptr : s.irq_stack_ptr};
			cprsf_pkg::SEL_VECTOR_TBL_BASE:
				v = {12'h0, s.vector_table_base};
			cprsf_pkg::SEL_INSTR_POINTER:
				v = {12'h0, s.pc};
			cprsf_pkg::SEL_CPU_FLAGS:
				v = {21'h0, s.cpu_flags};
			cprsf_pkg::SEL_DATA_REG_0_HIGH:
				v = {24'h0, s.bank[b][cprsf_pkg::BK_D0][15:8]};
			cprsf_pkg::SEL_DATA_REG_0_LOW:
				v = {24'h0, s.bank[b][cprsf_pkg::BK_D0][7:0]};
			cprsf_pkg::SEL_DATA_REG_1_HIGH:
				v = {24'h0, s.bank[b][cprsf_pkg::BK_D1][15:8]};
			cprsf_pkg::SEL_DATA_REG_1_LOW:
				v = {24'h0, s.bank[b][cprsf_pkg::BK_D1][7:0]};
			cprsf_pkg::SEL_WIDE_PAIR_LO:
				v = {s.bank[b][cprsf_pkg::BK_D2],
					s.bank[b][cprsf_pkg::BK_D0]};
			cprsf_pkg::SEL_WIDE_PAIR_HI:
				v = {s.bank[b][cprsf_pkg::BK_D3],
					s.bank[b][cprsf_pkg::BK_D1]};
			cprsf_pkg::SEL_WIDE_ADDR_PAIR:
				v = {s.bank[b][cprsf_pkg::BK_A1],
					s.bank[b][cprsf_pkg::BK_A0]};
			default:
				v = 32'h0;
		endcase
		return v;
	endfunction : rd_reg

	// ------------------------------------------------------------
	// register write decode
	// ------------------------------------------------------------
	function automatic cprsf_pkg::cprsf_state_t wr_reg(
		input cprsf_pkg::cprsf_state_t s,
		input logic [4:0]              sel,
		input logic [31:0]             d
	);
		cprsf_pkg::cprsf_state_t r;
		logic                    b;
		r = s;
		b = s.cpu_flags[cprsf_pkg::FLG_B];
		case (sel)
			cprsf_pkg::SEL_DATA_REG_0:
				r.bank[b][cprsf_pkg::BK_D0] = d[15:0];
			cprsf_pkg::SEL_DATA_REG_1:
				r.bank[b][cprsf_pkg::BK_D1] = d[15:0];
			cprsf_pkg::SEL_DATA_REG_2:
				r.bank[b][cprsf_pkg::BK_D2] = d[15:0];
			cprsf_pkg::SEL_DATA_REG_3:
				r.bank[b][cprsf_pkg::BK_D3] = d[15:0];
			cprsf_pkg::SEL_ADDR_REG_0:
				r.bank[b][cprsf_pkg::BK_A0] = d[15:0];
			cprsf_pkg::SEL_ADDR_REG_1:
				r.bank[b][cprsf_pkg::BK_A1] = d[15:0];
			cprsf_pkg::SEL_FRAME_BASE:
				r.bank[b][cprsf_pkg::BK_FB] = d[15:0];
			cprsf_pkg::SEL_STATIC_BASE:
				r.sb = d[15:0];
			cprsf_pkg::SEL_USER_STACK_PTR:
				r.user_stack_ptr = d[15:0];
			cprsf_pkg::SEL_IRQ_STACK_PTR:
				r.irq_stack_ptr = d[15:0];
			cprsf_pkg::SEL_ACTIVE_SP: begin
				if (s.cpu_flags[cprsf_pkg::FLG_U]) begin
					r.user_stack_ptr = d[15:0];
				end else begin
					r.irq_stack_ptr = d[15:0];
				end
			end
			cprsf_pkg::SEL_VECTOR_TBL_BASE:
				r.vector_table_base = d[19:0];
			cprsf_pkg::SEL_INSTR_POINTER:
				r.pc = d[19:0];
			cprsf_pkg::SEL_CPU_FLAGS:
				r.cpu_flags = d[10:0];
			cprsf_pkg::SEL_DATA_REG_0_HIGH:
				r.bank[b][cprsf_pkg::BK_D0][15:8] = d[7:0];
			cprsf_pkg::SEL_DATA_REG_0_LOW:
				r.bank[b][cprsf_pkg::BK_D0][7:0] = d[7:0];
			cprsf_pkg::SEL_DATA_REG_1_HIGH:
				r.bank[b][cprsf_pkg::BK_D1][15:8] = d[7:0];
			cprsf_pkg::SEL_DATA_REG_1_LOW:
				r.bank[b][cprsf_pkg::BK_D1][7:0] = d[7:0];
			cprsf_pkg::SEL_WIDE_PAIR_LO: begin
				r.bank[b][cprsf_pkg::BK_D2] = d[31:16];
				r.bank[b][cprsf_pkg::BK_D0] = d[15:0];
			end
			cprsf_pkg::SEL_WIDE_PAIR_HI: begin
				r.bank[b][cprsf_pkg::BK_D3] = d[31:16];
				r.bank[b][cprsf_pkg::BK_D1] = d[15:0];
			end
			cprsf_pkg::SEL_WIDE_ADDR_PAIR: begin
				r.bank[b][cprsf_pkg::BK_A1] = d[31:16];
				r.bank[b][cprsf_pkg::BK_A0] = d[15:0];
			end
			default:
				r = s;
		endcase
		return r;
	endfunction : wr_reg

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	cprsf_pkg::cprsf_state_t st;
	cprsf_pkg::cprsf_state_t next_st;

	logic [31:0] res_masked;
	logic        res_neg;
	logic [2:0]  cur_ipl;

	always_comb begin
		case (alu_in.size)
			cprsf_pkg::SZ_BYTE: begin
				res_masked = {24'h0, alu_in.result[7:0]};
				res_neg    = alu_in.result[7];
			end
			cprsf_pkg::SZ_LONG: begin
				res_masked = alu_in.result;
				res_neg    = alu_in.result[31];
			end
			default: begin
				res_masked = {16'h0, alu_in.result[15:0]};
				res_neg    = alu_in.result[15];
			end
		endcase
	end

	assign cur_ipl = st.cpu_flags[cprsf_pkg::FLG_IPL_HI:cprsf_pkg::FLG_IPL_LO];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// reads see the state before this cycle's writes; the software
	// port is applied after the datapath so it wins a collision,
	// and interrupt entry is applied last so it wins over both.
	always_comb begin
		next_st = st;
		next_st.bus_rdata = bus_in.rd ? rd_reg(st, bus_in.addr) : 32'h0;
		next_st.dp_rdata  = rd_reg(st, dp_rd_sel_in);
		if (dp_wr_in) begin
			next_st = wr_reg(next_st, dp_wr_sel_in, dp_wdata_in);
		end
		if (alu_in.upd) begin
			next_st.cpu_flags[cprsf_pkg::FLG_C] = alu_in.carry;
			next_st.cpu_flags[cprsf_pkg::FLG_Z] = (res_masked == 32'h0);
			next_st.cpu_flags[cprsf_pkg::FLG_S] = res_neg;
			next_st.cpu_flags[cprsf_pkg::FLG_O] = alu_in.ovf;
		end
		if (bus_in.wr) begin
			next_st = wr_reg(next_st, bus_in.addr, bus_in.wdata);
		end
		if (irq_in.ack) begin
			next_st.cpu_flags[cprsf_pkg::FLG_I] = 1'b0;
			next_st.cpu_flags[cprsf_pkg::FLG_U] = 1'b0;
		end
		if (irq_in.swi && (irq_in.swi_num <= cprsf_pkg::SWI_SYS_MAX)) begin
			next_st.cpu_flags[cprsf_pkg::FLG_U] = 1'b0;
		end
		// acceptance uses the flags as they stand, not as written now
		next_st.irq_take = irq_in.req
			&& st.cpu_flags[cprsf_pkg::FLG_I]
			&& (irq_in.prio > cur_ipl);
		next_st.sp_view = next_st.cpu_flags[cprsf_pkg::FLG_U]
			? next_st.user_stack_ptr : next_st.irq_stack_ptr;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			for (int i = 0; i < cprsf_pkg::BANKS; i++) begin
				for (int j = 0; j < cprsf_pkg::BK_SLOTS; j++) begin
					st.bank[i][j] <= cprsf_pkg::RST_WORD;
				end
			end
			st.vector_table_base      <= cprsf_pkg::RST_ADDR20;
			st.pc        <= cprsf_pkg::RST_ADDR20;
			st.user_stack_ptr       <= cprsf_pkg::RST_WORD;
			st.irq_stack_ptr       <= cprsf_pkg::RST_WORD;
			st.sb        <= cprsf_pkg::RST_WORD;
			st.cpu_flags       <= cprsf_pkg::RST_FLAGS;
			st.bus_rdata <= 32'h0;
			st.dp_rdata  <= 32'h0;
			st.sp_view   <= cprsf_pkg::RST_WORD;
			st.irq_take  <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign bus_rdata_out         = st.bus_rdata;
	assign dp_rdata_out          = st.dp_rdata;
	assign irq_take_out          = st.irq_take;
	assign cpu_flags_out         = st.cpu_flags;
	assign instr_pointer_out     = st.pc;
	assign vector_table_base_out = st.vector_table_base;
	assign active_sp_out         = st.sp_view;

endmodule : cprsf_core

// ### dv/cprsf_core_chk.sv
`timescale 1ns/100ps
module cprsf_core_chk (
	// clock and reset
	input wire logic                  clk_in,
	input wire logic                  srst_in,
	// watched ports
	input wire cprsf_pkg::cprsf_bus_t bus_in,
	input wire logic [31:0]           bus_rdata_out,
	input wire cprsf_pkg::cprsf_alu_t alu_in,
	input wire cprsf_pkg::cprsf_irq_t irq_in,
	input wire logic                  irq_take_out,
	input wire logic [10:0]           cpu_flags_out,
	input wire logic [19:0]           instr_pointer_out
);
	// previous-cycle copies keep $past off struct members
	cprsf_pkg::cprsf_alu_t alu_q;
	cprsf_pkg::cprsf_bus_t bus_q;
	always_ff @(posedge clk_in) begin
		alu_q <= alu_in;
		bus_q <= bus_in;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	sequence s_flag_rd; bus_in.rd && bus_in.addr == 5'h0D; endsequence
	// a port write to the flags overrides the alu update in that cycle
	sequence s_alu;
		alu_in.upd && !(bus_in.wr && bus_in.addr == 5'h0D);
	endsequence
	property p_rd_flags;
		s_flag_rd |=> bus_rdata_out == {21'h0, $past(cpu_flags_out)};
	endproperty
	a_rd_flags: assert property (p_rd_flags)
		else $error("flag read data wrong");
	property p_alu_co; s_alu |=> cpu_flags_out[0] == alu_q.carry
		&& cpu_flags_out[5] == alu_q.ovf; endproperty
	a_alu_co: assert property (p_alu_co)
		else $error("carry or overflow flag wrong");
	property p_alu_zs; s_alu ##0 alu_in.size == 2'h1 |=> cpu_flags_out[3:2]
		== {alu_q.result[15], alu_q.result[15:0] == 16'h0}; endproperty
	a_alu_zs: assert property (p_alu_zs)
		else $error("zero or sign flag wrong");
	property p_take; irq_in.req && cpu_flags_out[6]
		&& irq_in.prio > cpu_flags_out[10:8] |=> irq_take_out; endproperty
	a_take: assert property (p_take)
		else $error("eligible request not taken");
	property p_no_take; !irq_in.req || !cpu_flags_out[6]
		|| irq_in.prio <= cpu_flags_out[10:8] |=> !irq_take_out; endproperty
	a_no_take: assert property (p_no_take)
		else $error("blocked request taken");
	property p_ack; irq_in.ack |=> cpu_flags_out[7:6] == 2'h0; endproperty
	a_ack: assert property (p_ack)
		else $error("acknowledge left enable or stack flag set");
	property p_swi; irq_in.swi && irq_in.swi_num <= 6'h1F
		|=> !cpu_flags_out[7]; endproperty
	a_swi: assert property (p_swi)
		else $error("low trap left stack flag set");
	property p_pc; bus_in.wr && bus_in.addr == 5'h0C
		|=> instr_pointer_out == bus_q.wdata[19:0]; endproperty
	a_pc: assert property (p_pc)
		else $error("instruction pointer write lost");
endmodule : cprsf_core_chk

bind cprsf_core cprsf_core_chk u_chk (.clk_in(clk_in), .srst_in(srst_in),
	.bus_in(bus_in), .bus_rdata_out(bus_rdata_out), .alu_in(alu_in),
	.irq_in(irq_in), .irq_take_out(irq_take_out),
	.cpu_flags_out(cpu_flags_out), .instr_pointer_out(instr_pointer_out));

// ### dv/cprsf_core_tb.sv
`timescale 1ns/100ps
module cprsf_core_tb;
	logic                  clk_in = 1'b0;
	logic                  srst_in = 1'b1;
	cprsf_pkg::cprsf_bus_t bus = '0;
	cprsf_pkg::cprsf_alu_t alu = '0;
	cprsf_pkg::cprsf_irq_t irq = '0;
	logic [4:0]            dp_rs = '0;
	logic                  dp_we = 1'b0;
	logic [31:0]           dp_wd = '0;
	logic [31:0]           rdata;
	logic [31:0]           dp_rdata;
	logic [10:0]           flags;
	logic [19:0]           pc;
	logic [19:0]           vtb;
	logic [15:0]           asp;
	logic                  take;
	int                    errors = 0;
	int                    num_checks = 0;
	always #2.5 clk_in = ~clk_in;
	cprsf_core dut (.clk_in(clk_in), .srst_in(srst_in), .bus_in(bus),
		.bus_rdata_out(rdata), .dp_rd_sel_in(dp_rs), .dp_wr_in(dp_we),
		.dp_wr_sel_in(dp_rs), .dp_wdata_in(dp_wd), .dp_rdata_out(dp_rdata),
		.alu_in(alu), .irq_in(irq), .irq_take_out(take),
		.cpu_flags_out(flags), .instr_pointer_out(pc),
		.vector_table_base_out(vtb), .active_sp_out(asp));
	task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_in);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		bus.wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge clk_in);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		bus.rd <= 1'b0;
		#1 chk($sformatf("read %h", a), e, rdata);
	endtask : rd
	// one-cycle pulse on the interrupt inputs
	task automatic pulse(input cprsf_pkg::cprsf_irq_t v);
		@(posedge clk_in);
		irq <= v;
		@(posedge clk_in);
		irq <= '0;
		#1;
	endtask : pulse
	task automatic alu_op(input logic [1:0] s, input logic [31:0] r,
		input logic c, input logic o, input logic [10:0] e);
		@(posedge clk_in);
		alu <= '{upd: 1'b1, carry: c, ovf: o, size: s, result: r};
		@(posedge clk_in);
		alu.upd <= 1'b0;
		#1 chk("alu flags", 32'(e), 32'(flags));
	endtask : alu_op
	task results;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	initial begin
		repeat (16) @(posedge clk_in);
		srst_in <= 1'b0;
		for (int i = 0; i < 14; i++) rd(5'(i), 32'h0);
		for (int i = 0; i < 13; i++) if (i != 10) begin
			wr(5'(i), 32'hFFFFFFFF);
			rd(5'(i), i > 10 ? 32'h000FFFFF : 32'h0000FFFF);
		end
		chk("instr pointer", 32'h000FFFFF, 32'(pc));
		chk("vector base", 32'h000FFFFF, 32'(vtb));
		wr(5'h15, 32'h1234);
		rd(5'h15, 32'h0);
		$display("test widths done");
		wr(5'h0D, 32'hFFFFFFFD);
		rd(5'h0D, 32'h7FD);
		// read data stand for one cycle only, then fall back to zero
		@(posedge clk_in);
		#1 chk("read idle", 32'h0, rdata);
		rd(5'h00, 32'h0);
		pulse('{req: 1'b0, prio: 3'h0, ack: 1'b1, swi: 1'b0, swi_num: 6'h0});
		chk("flags after ack", 32'h73D, 32'(flags));
		wr(5'h0D, 32'h0);
		rd(5'h00, 32'hFFFF);
		wr(5'h0E, 32'hAB);
		wr(5'h0F, 32'hCD);
		wr(5'h11, 32'h12);
		rd(5'h00, 32'hABCD);
		rd(5'h10, 32'hFF);
		wr(5'h12, 32'h11112222);
		rd(5'h02, 32'h1111);
		rd(5'h13, 32'hFFFFFF12);
		wr(5'h14, 32'h33334444);
		rd(5'h05, 32'h3333);
		$display("test views done");
		wr(5'h08, 32'h1111);
		wr(5'h09, 32'h2222);
		rd(5'h0A, 32'h2222);
		wr(5'h0D, 32'h080);
		rd(5'h0A, 32'h1111);
		chk("active sp", 32'h1111, 32'(asp));
		pulse('{req: 1'b0, prio: 3'h0, ack: 1'b0, swi: 1'b1, swi_num: 6'h20});
		chk("flags after trap 32", 32'h080, 32'(flags));
		pulse('{req: 1'b0, prio: 3'h0, ack: 1'b0, swi: 1'b1, swi_num: 6'h1F});
		chk("flags after trap 31", 32'h0, 32'(flags));
		wr(5'h0D, 32'h240);
		for (int p = 0; p < 8; p++) begin
			pulse('{req: 1'b1, prio: 3'(p), ack: 1'b0, swi: 1'b0, swi_num: 6'h0});
			chk("take", 32'(p > 2), 32'(take));
		end
		wr(5'h0D, 32'h200);
		pulse('{req: 1'b1, prio: 3'h7, ack: 1'b0, swi: 1'b0, swi_num: 6'h0});
		chk("masked take", 32'h0, 32'(take));
		$display("test interrupts done");
		alu_op(2'h1, 32'hFFFF0000, 1'b1, 1'b0, 11'h205);
		alu_op(2'h0, 32'h00000180, 1'b0, 1'b1, 11'h228);
		alu_op(2'h2, 32'h80000000, 1'b0, 1'b0, 11'h208);
		alu_op(2'h2, 32'h00000000, 1'b1, 1'b1, 11'h225);
		@(posedge clk_in);
		dp_we <= 1'b1;
		dp_rs <= 5'h07;
		dp_wd <= 32'h5A5A;
		@(posedge clk_in);
		dp_we <= 1'b0;
		@(posedge clk_in);
		#1 chk("datapath read", 32'h5A5A, dp_rdata);
		$display("test alu and datapath done");
		// a second reset in mid-run must bring every view back to zero
		@(posedge clk_in);
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		#1 chk("flags after reset", 32'h0, 32'(flags));
		chk("pointer after reset", 32'h0, 32'(pc));
		chk("vector base after reset", 32'h0, 32'(vtb));
		chk("active sp after reset", 32'h0, 32'(asp));
		rd(5'h00, 32'h0);
		rd(5'h07, 32'h0);
		$display("test reset done");
		results();
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		errors++;
		results();
	end
endmodule : cprsf_core_tb
